// File: bench/pwm_channel_timer_props.sv
// port assertions for the channel timer
// assumes it is bound to the timer; one clock domain, sync reset
`timescale 1ns/10ps
module pwm_channel_timer_props (
    input wire logic       i_sys_clk,
    input wire logic       i_reset,
    input wire logic       i_tick,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_pwm,
    input wire logic       o_pwm_en
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    // ==========
    // register port and waveform
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero when idle");
    chk_unmapped_zero: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_count_clear: assert property ((i_wr && i_addr == 4'h3) ##1 (i_rd && i_addr == 4'h3)
        |=> o_rdata == 8'h00)
        else $error("counter not cleared by write");
    chk_count_stable: assert property ((i_rd && i_addr == 4'h3 && !i_tick) ##1
        (i_rd && i_addr == 4'h3) |=> o_rdata == $past(o_rdata))
        else $error("counter moved without a tick");
    chk_buffer_read: assert property ((i_wr && i_addr == 4'h1) ##1 (i_rd && i_addr == 4'h1)
        |=> o_rdata == $past(i_wdata, 2))
        else $error("period buffer readback wrong");
    chk_enable_follow: assert property ((i_wr && i_addr == 4'h0) ##1 !i_wr
        |-> ##1 o_pwm_en == $past(i_wdata[0], 2))
        else $error("output enable does not follow");
    chk_disabled_low: assert property (!o_pwm_en |-> !o_pwm)
        else $error("waveform while disabled");
    // waveform moves only after a tick, a write, or an enable change
    chk_pwm_cause: assert property ($changed(o_pwm)
        |-> $past(i_tick) || $past(i_wr) || $past(i_wr, 2))
        else $error("waveform changed without cause");
endmodule : pwm_channel_timer_props

bind pwm_channel_timer pwm_channel_timer_props u_props (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .i_tick(i_tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm), .o_pwm_en(o_pwm_en));

// File: bench/test_pwm_channel_timer.sv
// self-checking bench for the channel timer: table rows, then hand tests
// assumes design, package and checker compiled first
`timescale 1ns/10ps
module test_pwm_channel_timer;
    typedef struct packed {logic c; logic p; logic [7:0] per; logic [7:0] dty;
        logic [7:0] hi;} row_t;
    logic       i_sys_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic       i_tick = 1'b0;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       tick_on = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata, rdv, x;
    logic       o_pwm, o_pwm_en;
    int         bad_count = 0;
    int         checks = 0;
    int         h;
    // center, polarity, period, duty, high cycles per effective period
    row_t       rows [5] = '{'{1'b0, 1'b1, 8'h04, 8'h01, 8'h01},
        '{1'b0, 1'b0, 8'h04, 8'h01, 8'h03}, '{1'b1, 1'b1, 8'h04, 8'h01, 8'h02},
        '{1'b1, 1'b0, 8'h04, 8'h01, 8'h06}, '{1'b0, 1'b1, 8'h08, 8'h05, 8'h05}};

    pwm_channel_timer u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_tick(i_tick),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_pwm(o_pwm), .o_pwm_en(o_pwm_en));

    initial forever #10 i_sys_clk = ~i_sys_clk;
    // tick every cycle keeps expected counts simple
    always @(posedge i_sys_clk) i_tick <= tick_on;

    // ==========
    // bus and check tasks
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // strobe stays up so calls can run back to back
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
    endtask : bus
    task fin;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_sys_clk);
        rdv = o_rdata;
    endtask : fin
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        fin();
    endtask : wr
    task rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00);
        fin();
    endtask : rd
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        bad_count++;
        end_of_test();
    end

    // ==========
    // main sequence
    initial
    begin
        repeat (4) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        for (int a = 0; a < 6; a++)
        begin
            rd(a == 5 ? 4'hf : 4'(a));
            chk("reset read", 8'h00, rdv);
        end
        chk("reset pins", 8'h00, {6'h00, o_pwm, o_pwm_en});
        $display("done reset");
        tick_on <= 1'b1;
        foreach (rows[i])
        begin
            wr(4'h0, 8'h00);
            wr(4'h1, rows[i].per);
            wr(4'h2, rows[i].dty);
            wr(4'h3, 8'h00);
            wr(4'h0, {5'h00, rows[i].c, rows[i].p, 1'b1});
            repeat (40) @(posedge i_sys_clk);
            h = 0;
            repeat (rows[i].c ? 2 * rows[i].per : rows[i].per)
            begin
                @(posedge i_sys_clk);
                h += (o_pwm === 1'b1);
            end
            chk("high cycles", rows[i].hi, 8'(h));
            $display("done row %0d", i);
        end
        wr(4'h1, 8'hc8);
        repeat (20) @(posedge i_sys_clk);
        rd(4'h3);
        chk("loaded at period end", 8'h01, {7'h00, rdv > 8'h08});
        wr(4'h0, 8'h02);
        rd(4'h3);
        x = rdv;
        repeat (10) @(posedge i_sys_clk);
        rd(4'h3);
        chk("held count", x, rdv);
        tick_on <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        bus(1'b0, 4'h3, 8'h00);
        bus(1'b0, 4'h3, 8'h00);
        fin();
        tick_on <= 1'b1;
        wr(4'h0, 8'h03);
        repeat (10) @(posedge i_sys_clk);
        rd(4'h3);
        chk("resumed", 8'h01, {7'h00, rdv > x && rdv < x + 8'h14});
        wr(4'h0, 8'h02);
        wr(4'h1, 8'h00);
        repeat (3) @(posedge i_sys_clk);
        rd(4'h3);
        chk("period zero", 8'h00, rdv);
        wr(4'h1, 8'hc8);
        wr(4'h0, 8'h03);
        bus(1'b1, 4'h1, 8'h03);
        bus(1'b0, 4'h1, 8'h00);
        fin();
        chk("buffer", 8'h03, rdv);
        repeat (10) @(posedge i_sys_clk);
        rd(4'h3);
        chk("not yet loaded", 8'h01, {7'h00, rdv > 8'h03});
        bus(1'b1, 4'h3, 8'h55);
        bus(1'b0, 4'h3, 8'h00);
        fin();
        chk("count cleared", 8'h00, rdv);
        chk("start level", 8'h01, {7'h00, o_pwm});
        rd(4'h4);
        chk("status gate up ff clear", 8'h04, rdv);
        repeat (10) @(posedge i_sys_clk);
        rd(4'h3);
        chk("loaded by write", 8'h01, {7'h00, rdv < 8'h03});
        $display("done hand tests");
        end_of_test();
    end
endmodule : test_pwm_channel_timer

// File: rtl/pwm_channel_timer.sv
// one pwm channel timer: counter, double-buffered period and duty, polarity
// assumes a prescaler supplies a one-cycle tick on the bus clock
`timescale 1ns/10ps

// Operation
// RULE1: channel owns 8-bit counter, period and duty; period match sets waveform period
// RULE2: enable acts at once; waveform appears at next selected clock tick
// RULE3: channel clock gate switches only on a tick edge
// RULE4: counter holds while channel disabled
// RULE5: polarity 1 starts high goes low; polarity 0 starts low goes high
// RULE6: enabled writes go to buffer; latch on period end, counter write, disable
// RULE7: disabled writes load buffer and active latch together
// RULE8: 8-bit up/down counter advancing once per selected tick
// RULE9: counter equal to active duty toggles the output flip-flop
// RULE10: counter readable anytime without disturbing counting or output
// RULE11: counter write clears count, direction up, loads actives, output per polarity
// RULE12: re-enabled channel resumes from held count
// RULE13: disabled with period zero written, counter resets on next tick
// RULE14: counter write while enabled starts new period at polarity level
// RULE15: counter clears when effective period ends
// RULE16: software writes counter before enabling for a clean waveform
// RULE17: center select clear gives left aligned, set gives center aligned
// RULE18: left aligned counts up to period minus one, match resets and loads
// RULE19: center aligned reverses at period, at zero goes up and loads
// RULE20: prescaler tick pulse is the selected clock; all logic on bus clock
module pwm_channel_timer
    import pwm_channel_timer_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    // selected channel clock tick from prescaler
    input  wire logic             i_tick,
    // register port
    input  wire logic [3:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [7:0]       o_rdata,
    // channel output
    output logic                  o_pwm,
    output logic                  o_pwm_en
);

    // ==========================================================
    // elaboration check
    if (WIDTH != 8)
    begin : g_width_check
        $error("pwm_channel_timer supports an 8-bit channel only");
    end

    // ==========================================================
    // registers
    logic [7:0]       ctrl_q;
    logic [WIDTH-1:0] per_buf_q;
    logic [WIDTH-1:0] dty_buf_q;
    logic [WIDTH-1:0] per_act_q;
    logic [WIDTH-1:0] dty_act_q;
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    count_dir_t       dir_q;
    count_dir_t       dir_d;
    logic             ff_q;
    logic             ff_d;
    logic             gate_q;
    logic             load_d;

    logic enable;
    logic polarity;
    logic center;
    logic wr_ctrl;
    logic wr_per;
    logic wr_dty;
    logic wr_cnt;
    logic run;
    logic last_up;
    logic per_up;
    logic dty_up;
    logic dty_dn;
    logic zero_stop;

    assign enable   = ctrl_q[`CTRL_ENABLE_BIT];
    assign polarity = ctrl_q[`CTRL_POL_BIT];
    assign center   = ctrl_q[`CTRL_CENTER_BIT];   // see RULE17
    assign wr_ctrl  = i_wr && (i_addr == `ADDR_CTRL);
    assign wr_per   = i_wr && (i_addr == `ADDR_PERIOD);
    assign wr_dty   = i_wr && (i_addr == `ADDR_DUTY);
    assign wr_cnt   = i_wr && (i_addr == `ADDR_COUNTER);
    assign run      = gate_q && i_tick;           // see RULE20

    // ==========================================================
    // match terms
    // compared on the count being entered, so a toggle lines up with the new count
    assign last_up   = (cnt_q == per_act_q - 8'h01);
    assign per_up    = (cnt_q + 8'h01 == per_act_q);
    assign dty_up    = (cnt_q + 8'h01 == dty_act_q);
    assign dty_dn    = (cnt_q - 8'h01 == dty_act_q);
    // period zero while stopped parks the count; needs a tick like any other step
    assign zero_stop = !gate_q && i_tick && (per_act_q == '0);   // see RULE13

    // ==========================================================
    // control register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ctrl_q <= `CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= {5'h0, i_wdata[2:0]};
        end
    end

    // ==========================================================
    // clock gate: follows enable only on a tick, so no partial channel cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            gate_q <= 1'b0;
        end
        else if (i_tick)
        begin
            gate_q <= enable;                     // see RULE2 see RULE3
        end
    end

    // ==========================================================
    // buffers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            per_buf_q <= `PERIOD_RESET;
            dty_buf_q <= `DUTY_RESET;
        end
        else
        begin
            if (wr_per)
            begin
                per_buf_q <= i_wdata[WIDTH-1:0];  // see RULE6
            end
            if (wr_dty)
            begin
                dty_buf_q <= i_wdata[WIDTH-1:0];
            end
        end
    end

    // ==========================================================
    // counter, direction and output flip-flop next state
    always_comb
    begin
        cnt_d  = cnt_q;
        dir_d  = dir_q;
        ff_d   = ff_q;
        load_d = 1'b0;
        if (wr_cnt)
        begin
            cnt_d  = '0;                          // see RULE11 see RULE14
            dir_d  = DIR_UP;
            ff_d   = 1'b0;
            load_d = 1'b1;
        end
        else if (run)                             // see RULE4 see RULE12
        begin
            if (!center)
            begin
                if (per_act_q == '0 || last_up)
                begin
                    cnt_d  = '0;                  // see RULE15 see RULE18
                    ff_d   = 1'b0;
                    load_d = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q + 8'h01;        // see RULE8
                    if (dty_up)
                    begin
                        ff_d = ~ff_q;             // see RULE9
                    end
                end
            end
            else if (per_act_q == '0)
            begin
                cnt_d  = '0;
                dir_d  = DIR_UP;
                ff_d   = 1'b0;
                load_d = 1'b1;
            end
            else if (dir_q == DIR_UP)
            begin
                cnt_d = cnt_q + 8'h01;
                if (per_up)
                begin
                    dir_d = DIR_DOWN;             // see RULE19
                end
                if (dty_up)
                begin
                    ff_d = ~ff_q;
                end
            end
            else
            begin
                cnt_d = cnt_q - 8'h01;
                if (dty_dn)
                begin
                    ff_d = ~ff_q;
                end
                if (cnt_q == 8'h01)
                begin
                    dir_d  = DIR_UP;              // see RULE15 see RULE19
                    ff_d   = 1'b0;
                    load_d = 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // counter register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            cnt_q <= `COUNT_RESET;
        end
        else if (zero_stop)
        begin
            cnt_q <= '0;                          // see RULE13
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // ==========================================================
    // count direction
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            dir_q <= DIR_UP;
        end
        else if (zero_stop)
        begin
            dir_q <= DIR_UP;
        end
        else
        begin
            dir_q <= dir_d;
        end
    end

    // ==========================================================
    // output flip-flop
    // zero is the start level; polarity is applied only at the pin
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ff_q <= 1'b0;
        end
        else if (zero_stop)
        begin
            ff_q <= 1'b0;
        end
        else
        begin
            ff_q <= ff_d;
        end
    end

    // ==========================================================
    // active latches: direct while disabled, else on period end or counter write
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            per_act_q <= `PERIOD_RESET;
            dty_act_q <= `DUTY_RESET;
        end
        else if (!enable)
        begin
            per_act_q <= wr_per ? i_wdata[WIDTH-1:0] : per_buf_q;   // see RULE7 see RULE6
            dty_act_q <= wr_dty ? i_wdata[WIDTH-1:0] : dty_buf_q;
        end
        else if (load_d)
        begin
            per_act_q <= per_buf_q;               // see RULE6 see RULE11
            dty_act_q <= dty_buf_q;
        end
    end

    // ==========================================================
    // output: flip-flop zero means start level, polarity picks q or not q
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_pwm    <= 1'b0;
            o_pwm_en <= 1'b0;
        end
        else
        begin
            o_pwm    <= enable & (polarity ^ ff_d);   // see RULE5 see RULE1
            o_pwm_en <= enable;                       // see RULE2
        end
    end

    // ==========================================================
    // read port: no side effects, so reads never disturb counting
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `ADDR_CTRL:    o_rdata <= ctrl_q;
                `ADDR_PERIOD:  o_rdata <= per_buf_q;
                `ADDR_DUTY:    o_rdata <= dty_buf_q;
                `ADDR_COUNTER: o_rdata <= cnt_q;      // see RULE10
                `ADDR_STATUS:  o_rdata <= {5'h0, gate_q, dir_q == DIR_DOWN, ff_q};
                default:       o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            // idle zero lets a wired-or bus share the read lines
            o_rdata <= 8'h00;
        end
    end

endmodule : pwm_channel_timer

// File: rtl/pwm_channel_timer_pkg.sv
// types shared by the channel timer
// assumes the register header is found on the include path
package pwm_channel_timer_pkg;
    `include "pwm_channel_timer_regs.svh"

    // ==========================================================
    // count direction
    typedef enum logic
    {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;
endpackage : pwm_channel_timer_pkg

// File: rtl/pwm_channel_timer_regs.svh
// register offsets, field positions, reset values for the channel timer
// assumes inclusion from the package only
`ifndef PWM_CHANNEL_TIMER_REGS_SVH
`define PWM_CHANNEL_TIMER_REGS_SVH

// ==========================================================
// register offsets (word index on the plain register port)
`define ADDR_CTRL        4'h0
`define ADDR_PERIOD      4'h1
`define ADDR_DUTY        4'h2
`define ADDR_COUNTER     4'h3
`define ADDR_STATUS      4'h4

// ==========================================================
// control field positions
`define CTRL_ENABLE_BIT  0
`define CTRL_POL_BIT     1
`define CTRL_CENTER_BIT  2

// ==========================================================
// status field positions
`define STAT_OUT_BIT     0
`define STAT_DOWN_BIT    1
`define STAT_GATE_BIT    2

// ==========================================================
// reset values
`define CTRL_RESET       8'h00
`define PERIOD_RESET     8'h00
`define DUTY_RESET       8'h00
`define COUNT_RESET      8'h00

`endif
